// >>> hw/mdc_memory.sv
// Memory end: arbiter, cycle timing, RAM strobes, refresh and the array.
// Assumes ports follow the request/select handshake on the shared bus.
// ==========================================================
module mdc_memory
  import mdc_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Port bus
  mdc_if.memory             bus,
  // RAM chip strobes, for observation
  output logic [RA_W-1:0]   ram_addr,
  output logic              ram_row_strobe_n,
  output logic              ram_col_strobe_n
);

  // ==========================================================
  // Storage and state
  logic [DATA_W-1:0] mem_q [WORDS_16];      // Narrow view of the array
  mdc_state_t        state_q;               // Cycle state
  logic [3:0]        step_q;                // Step within a cycle
  logic [PIDX_W-1:0] owner_q;               // Port granted
  logic [NPORT-1:0]  sel_q;                 // Grant select lines
  logic [ADDR_W-1:0] addr_q;                // Latched cycle address
  logic              rd_q;                  // Latched read flag
  logic              wide_q;                // Latched wide flag
  logic [RA_W-1:0]   row_cnt_q;             // Refresh row counter
  logic [15:0]       ref_tmr_q;             // Refresh interval timer
  logic              ref_pend_q;            // Refresh request, active high
  logic [NPORT-1:0]  req_act;               // Active-high requests
  logic [PIDX_W-1:0] win;                   // Arbitration winner
  logic              any_req;               // Any request pending
  logic [WIDX_W-1:0] widx;                  // Wide location index
  logic [WIDE_W-1:0] wide_word;             // Four assembled words

  // ==========================================================
  // Requests: refresh is internal, others arrive active low
  always_comb
  begin
    req_act = ~bus.port_request_n;
    req_act[P_REFRESH] = ref_pend_q;
  end

  // Priority encoder, lowest index wins
  always_comb
  begin
    win     = P_REFRESH;
    any_req = |req_act;
    if (req_act[P_DISP])
      win = P_DISP;
    else if (req_act[P_CPU])
      win = P_CPU;
    else if (req_act[P_FETCH])
      win = P_FETCH;
  end

  // ==========================================================
  // Cycle sequencer: runs regardless of the processor
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      step_q  <= 4'h0;
      owner_q <= P_DISP;
      sel_q   <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          step_q <= 4'h0;
          if (any_req)
          begin
            owner_q <= win;
            sel_q   <= NPORT'(1) << win;
            state_q <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          // Select held even once the request line rises
          step_q <= step_q + 4'h1;
          if (step_q == T_LAST)
            state_q <= ST_DONE;
        end
        ST_DONE:
        begin
          // Drop select before the next arbitration
          sel_q   <= '0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Capture address and qualifiers at the start of a cycle
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addr_q <= '0;
      rd_q   <= 1'b1;
      wide_q <= 1'b0;
    end
    else if (state_q == ST_RUN && step_q == 4'h0)
    begin
      if (owner_q == P_REFRESH)
      begin
        // Refresh is a read of the counted row; the row half sits above the word select
        addr_q <= ADDR_W'({row_cnt_q, {WSEL_W{1'b0}}});
        rd_q   <= 1'b1;
        wide_q <= 1'b1;
      end
      else
      begin
        addr_q <= bus.addr;
        rd_q   <= bus.rd_wr_n;
        wide_q <= bus.wide_rd & bus.rd_wr_n;
      end
    end
  end

  // ==========================================================
  // Handshake strobes
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus.write_data_gate    <= 1'b0;
      bus.read_sample_strobe <= 1'b1;
      bus.request_clear      <= 1'b0;
      bus.mem_data_oe        <= 1'b0;
    end
    else
    begin
      // Gate spans the write from the step after capture to the step before the last
      bus.write_data_gate <= (state_q == ST_RUN) && !rd_q &&
                             step_q >= 4'h1 && step_q < T_LAST;
      bus.request_clear   <= (state_q == ST_RUN) && (step_q == T_CLR);
      bus.read_sample_strobe <= !((state_q == ST_RUN) && rd_q &&
                                 step_q == T_SAMPLE && owner_q != P_REFRESH);
      bus.mem_data_oe     <= (state_q == ST_RUN) && rd_q && !wide_q &&
                             owner_q != P_REFRESH && step_q >= T_COL;
    end
  end

  always_comb
    bus.port_grant_select = sel_q;

  // ==========================================================
  // RAM strobes: row first, column later with R/W settled
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ram_row_strobe_n <= 1'b1;
      ram_col_strobe_n <= 1'b1;
      ram_addr         <= '0;
    end
    else
    begin
      ram_row_strobe_n <= !((state_q == ST_RUN) && step_q >= T_ROW);
      // Column strobe on writes too: the chips take R/W at this edge
      ram_col_strobe_n <= !((state_q == ST_RUN) && step_q >= T_COL);
      // Row half then column half of the 14-bit chip address
      ram_addr <= (step_q < T_COL) ? addr_q[RA_W+WSEL_W-1:WSEL_W]
                                   : addr_q[2*RA_W+WSEL_W-1:RA_W+WSEL_W];
    end
  end

  // ==========================================================
  // Array write, one narrow word at the column step
  always_ff @(posedge core_clk)
  begin
    if (state_q == ST_RUN && step_q == T_COL && !rd_q && bus.port_data_oe)
      mem_q[addr_q[WIDX_W+WSEL_W-1:0]] <= bus.port_data;
  end

  // Wide read assembly of four aligned words
  assign widx = addr_q[WIDX_W+WSEL_W-1:WSEL_W];
  genvar g;
  generate
    for (g = 0; g < WIDE_W / DATA_W; g++)
    begin : g_wide
      assign wide_word[g*DATA_W +: DATA_W] = mem_q[{widx, WSEL_W'(g)}];
    end
  endgenerate

  // Read data registers
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus.wide_data <= '0;
      bus.mem_data  <= '0;
    end
    else if (state_q == ST_RUN && step_q == T_COL && rd_q)
    begin
      bus.wide_data <= wide_word;
      bus.mem_data  <= wide_word[addr_q[WSEL_W-1:0]*DATA_W +: DATA_W];
    end
  end

  // ==========================================================
  // Refresh: a timer spreads one row read per slot
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ref_tmr_q  <= '0;
      ref_pend_q <= 1'b0;
      row_cnt_q  <= '0;
    end
    else
    begin
      if (ref_tmr_q == 16'(REFRESH_CYC - 1))
        ref_tmr_q <= '0;
      else
        ref_tmr_q <= ref_tmr_q + 16'h1;
      // Set wins over the grant clearing it
      if (ref_tmr_q == 16'(REFRESH_CYC - 1))
        ref_pend_q <= 1'b1;
      else if (state_q == ST_RUN && step_q == T_CLR && owner_q == P_REFRESH)
        ref_pend_q <= 1'b0;
      // Row steps on every served refresh, so no row is skipped on a clash
      if (state_q == ST_RUN && step_q == T_CLR && owner_q == P_REFRESH)
        row_cnt_q <= row_cnt_q + 7'h1;
    end
  end

endmodule : mdc_memory

// >>> pkg/mdc_pkg.sv
// Shared constants and types for the multiport memory cycle control.
// Assumes a single 100 MHz core clock and an active-low async reset.
package mdc_pkg;

  // ==========================================================
  // Widths
  localparam int unsigned ADDR_W    = 18;   // Word address bus
  localparam int unsigned DATA_W    = 16;   // Single-word data bus
  localparam int unsigned WIDE_W    = 64;   // Four-word read bus
  localparam int unsigned NPORT     = 4;    // Requesting ports
  localparam int unsigned PIDX_W    = 2;    // Port index width
  localparam int unsigned RA_W      = 7;    // RAM chip address pins
  localparam int unsigned WORDS_64  = 32768; // Wide locations
  localparam int unsigned WORDS_16  = 131072; // Narrow locations
  localparam int unsigned WSEL_W    = 2;    // Word select bits
  localparam int unsigned WIDX_W    = 15;   // Wide index bits
  localparam int unsigned ROWS      = 128;  // Row addresses

  // ==========================================================
  // Port indices, highest priority first
  localparam logic [1:0] P_DISP    = 2'h0;  // Display processor
  localparam logic [1:0] P_CPU     = 2'h1;  // CPU data port
  localparam logic [1:0] P_FETCH   = 2'h2;  // Instruction fetch unit
  localparam logic [1:0] P_REFRESH = 2'h3;  // Refresh port

  // ==========================================================
  // Cycle timing, in core clocks
  localparam logic [3:0] T_ROW     = 4'h1;  // Row strobe falls
  localparam logic [3:0] T_COL     = 4'h3;  // Column strobe falls
  localparam logic [3:0] T_CLR     = 4'h4;  // Request clear pulse
  localparam logic [3:0] T_SAMPLE  = 4'h5;  // Read sample strobe
  localparam logic [3:0] T_LAST    = 4'h7;  // Final cycle step
  localparam int unsigned REFRESH_MS = 2;   // Refresh interval, ms
  localparam int unsigned CLK_MHZ    = 100; // Core clock rate
  localparam int unsigned REFRESH_CYC = REFRESH_MS * 1000 * CLK_MHZ / ROWS;

  // ==========================================================
  // Cycle states, Gray from idle to done; the return to idle flips both bits
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b11
  } mdc_state_t;

endpackage : mdc_pkg

// >>> pkg/mdc_if.sv
// Memory port bus joining the cycle control and the requesting ports.
// Data lines run one per direction; the drive enables qualify them.
interface mdc_if;
  import mdc_pkg::*;
  // Per-port handshake
  logic [NPORT-1:0]  port_request_n;      // Low requests a cycle
  logic [NPORT-1:0]  port_grant_select;   // High grants a cycle
  // Shared cycle controls
  logic              write_data_gate;     // Port drives write word
  logic              read_sample_strobe;  // Falls when data is valid
  logic              request_clear;       // Clears granted request
  // Address and qualifiers from the granted port
  logic [ADDR_W-1:0] addr;                // Word address
  logic              rd_wr_n;             // High read, low write
  logic              wide_rd;             // High 64-bit read
  // Data
  logic [DATA_W-1:0] mem_data;            // Memory drives on reads
  logic              mem_data_oe;         // Memory output enable
  logic [DATA_W-1:0] port_data;           // Port drives on writes
  logic              port_data_oe;        // Port output enable
  logic [WIDE_W-1:0] wide_data;           // Read-only wide bus

  modport memory (
    input  port_request_n, addr, rd_wr_n, wide_rd, port_data, port_data_oe,
    output port_grant_select, write_data_gate, read_sample_strobe, request_clear,
           mem_data, mem_data_oe, wide_data
  );
  modport port (
    input  port_grant_select, write_data_gate, read_sample_strobe, request_clear,
           mem_data, mem_data_oe, wide_data,
    output port_request_n, addr, rd_wr_n, wide_rd, port_data, port_data_oe
  );
endinterface : mdc_if

// >>> hw/mdc_port.sv
// Requesting port end: raises a request, drives the bus while selected.
// Assumes the memory end answers per the shared handshake.
module mdc_port
  import mdc_pkg::*;
#(
  parameter logic [PIDX_W-1:0] PORT = P_CPU  // Which request line is ours
)
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Port bus
  mdc_if.port               bus,
  // User request
  input  wire logic         usr_start,       // Pulse to start a cycle
  input  wire logic         usr_read,        // High for read
  input  wire logic         usr_wide,        // High for 64-bit read
  input  wire logic [ADDR_W-1:0] usr_addr,   // Word address
  input  wire logic [DATA_W-1:0] usr_wdata,  // Write word
  // User answer
  output logic              usr_busy,        // Cycle outstanding
  output logic              usr_done,        // One-cycle completion
  output logic [DATA_W-1:0] usr_rdata,       // Narrow read word
  output logic [WIDE_W-1:0] usr_wide_rdata   // Wide read words
);

  // ==========================================================
  // Local state
  logic              req_q;                  // Request held, active high
  logic              rd_q;                   // Latched direction
  logic              wide_q;                 // Latched width
  logic [ADDR_W-1:0] addr_q;                 // Latched address
  logic [DATA_W-1:0] wdata_q;                // Latched write word
  logic              sel_d1_q;               // Select one clock ago
  logic              sel;                    // Our select line

  assign sel = bus.port_grant_select[PORT];

  // ==========================================================
  // Request line, cleared by the memory's clear pulse
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      req_q  <= 1'b0;
      rd_q   <= 1'b1;
      wide_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
    end
    else if (usr_start && !usr_busy)
    begin
      req_q   <= 1'b1;
      rd_q    <= usr_read;
      wide_q  <= usr_wide;
      addr_q  <= usr_addr;
      wdata_q <= usr_wdata;
    end
    else if (sel && bus.request_clear)
      req_q <= 1'b0;
  end

  // Own request line only; the other lines belong to other ports
  assign bus.port_request_n[PORT] = !req_q;

  // ==========================================================
  // Address and qualifiers driven while selected; the write word is driven always
  always_comb
  begin
    bus.addr         = sel ? addr_q : '0;
    bus.rd_wr_n      = sel ? rd_q : 1'b1;
    bus.wide_rd      = sel ? wide_q : 1'b0;
    bus.port_data    = wdata_q;
    bus.port_data_oe = sel && bus.write_data_gate;
  end

  // ==========================================================
  // Answer capture on the sample strobe and end of select
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      usr_busy       <= 1'b0;
      usr_done       <= 1'b0;
      usr_rdata      <= '0;
      usr_wide_rdata <= '0;
      sel_d1_q       <= 1'b0;
    end
    else
    begin
      sel_d1_q <= sel;
      usr_done <= sel_d1_q && !sel;
      if (usr_start && !usr_busy)
        usr_busy <= 1'b1;
      else if (sel_d1_q && !sel)
        usr_busy <= 1'b0;
      if (sel && !bus.read_sample_strobe)
      begin
        usr_rdata      <= bus.mem_data;
        usr_wide_rdata <= bus.wide_data;
      end
    end
  end

endmodule : mdc_port

// >>> verification/mdc_chk_sva.sv
// Concurrent checks on the memory port bus and the RAM strobes.
// Instantiated by the bench beside the bus; it sees signals only.
module mdc_chk
  import mdc_pkg::*;
(
  // Clock and reset
  input wire logic             core_clk,
  input wire logic             rstn,
  // Port bus
  input wire logic [NPORT-1:0] port_request_n,
  input wire logic [NPORT-1:0] port_grant_select,
  input wire logic             write_data_gate,
  input wire logic             read_sample_strobe,
  input wire logic             request_clear,
  input wire logic             rd_wr_n,
  input wire logic             mem_data_oe,
  input wire logic             port_data_oe,
  // RAM strobes
  input wire logic             ram_row_strobe_n,
  input wire logic             ram_col_strobe_n
);
  // =====================
  // Helpers
  logic ext_sel; // Some outside port holds a grant
  assign ext_sel = |port_grant_select[2:0];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // =====================
  // Properties
  property p_one_sel;
    $onehot0(port_grant_select);
  endproperty
  // Select stands the whole cycle, even after the request goes away
  property p_sel_hold;
    $rose(|port_grant_select) |=> $stable(port_grant_select)[*8] ##1
      (port_grant_select == 4'h0);
  endproperty
  property p_grant_req;
    $rose(ext_sel) |-> (port_grant_select[2:0] & ~$past(port_request_n[2:0])) != 3'h0;
  endproperty
  // Lower index wins; refresh bit excluded from the pending set
  property p_priority;
    $rose(|port_grant_select) |->
      ((port_grant_select - 4'h1) & ~$past(port_request_n) & 4'h7) == 4'h0;
  endproperty
  property p_clear_time;
    $rose(ext_sel) |-> ##5 request_clear ##1 !request_clear;
  endproperty
  property p_sample_time;
    $rose(ext_sel) && rd_wr_n |-> ##6 !read_sample_strobe ##1 read_sample_strobe;
  endproperty
  property p_sample_rd;
    !read_sample_strobe |-> ext_sel && rd_wr_n;
  endproperty
  property p_gate_wr;
    write_data_gate |-> (|port_grant_select) && !rd_wr_n;
  endproperty
  property p_mem_oe;
    mem_data_oe |-> rd_wr_n && !port_data_oe;
  endproperty
  property p_row_col;
    $fell(ram_col_strobe_n) |-> !ram_row_strobe_n && !$past(ram_row_strobe_n);
  endproperty

  // =====================
  // Assertions
  a_one_sel:     assert property (p_one_sel)     else $error("two selects high");
  a_sel_hold:    assert property (p_sel_hold)    else $error("select not held");
  a_grant_req:   assert property (p_grant_req)   else $error("grant without request");
  a_priority:    assert property (p_priority)    else $error("priority order broken");
  a_clear_time:  assert property (p_clear_time)  else $error("clear pulse misplaced");
  a_sample_time: assert property (p_sample_time) else $error("sample strobe late");
  a_sample_rd:   assert property (p_sample_rd)   else $error("sample outside read");
  a_gate_wr:     assert property (p_gate_wr)     else $error("gate outside write");
  a_mem_oe:      assert property (p_mem_oe)      else $error("data bus contention");
  a_row_col:     assert property (p_row_col)     else $error("column before row");

  // =====================
  // Coverage
  c_write:   cover property ($rose(write_data_gate));
  c_read:    cover property ($fell(read_sample_strobe));
  c_refresh: cover property ($rose(port_grant_select[3]));
  c_disp:    cover property ($rose(port_grant_select[0]));
endmodule : mdc_chk

// >>> verification/multiport_dram_memory_control_tb.sv
// Bench for the memory end with one CPU port and two scripted requesters.
// Assumes only the CPU port instance drives the shared address lines.
module multiport_dram_memory_control_tb
  import mdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // =====================
  // Signals
  logic              core_clk = 1'b0;
  logic              rstn = 1'b0;
  logic              usr_start = 1'b0;
  logic              usr_read = 1'b0;
  logic              usr_wide = 1'b0;
  logic [ADDR_W-1:0] usr_addr = '0;
  logic [DATA_W-1:0] usr_wdata = '0;
  logic              usr_busy, usr_done;
  logic [DATA_W-1:0] usr_rdata;
  logic [WIDE_W-1:0] usr_wide_rdata;
  logic [RA_W-1:0]   ram_addr, last_row, cpu_row, cpu_col;
  logic              row_n, col_n, row_q, col_q;
  logic              disp_req_n = 1'b1; // Scripted display requester
  logic              fetch_req_n = 1'b1; // Scripted fetch requester
  logic [NPORT-1:0]  sel_q = '0;
  logic [ADDR_W-1:0] seen_addr, base [2];
  logic [DATA_W-1:0] w [4];
  int                error_cnt, comparisons, cyc, last_ref, gap_max, ref_rows;
  int                order_q [$];

  always #5 core_clk = ~core_clk;
  mdc_if bus ();
  // Outside requesters own their bits; refresh is internal
  assign bus.port_request_n[0] = disp_req_n;
  assign bus.port_request_n[2] = fetch_req_n;
  assign bus.port_request_n[3] = 1'b1;

  mdc_memory mdc_memory_inst (.core_clk(core_clk), .rstn(rstn), .bus(bus),
    .ram_addr(ram_addr), .ram_row_strobe_n(row_n), .ram_col_strobe_n(col_n));
  mdc_port #(.PORT(P_CPU)) mdc_port_inst (.core_clk(core_clk), .rstn(rstn), .bus(bus),
    .usr_start(usr_start), .usr_read(usr_read), .usr_wide(usr_wide),
    .usr_addr(usr_addr), .usr_wdata(usr_wdata), .usr_busy(usr_busy),
    .usr_done(usr_done), .usr_rdata(usr_rdata), .usr_wide_rdata(usr_wide_rdata));
  mdc_chk mdc_chk_inst (.core_clk(core_clk), .rstn(rstn),
    .port_request_n(bus.port_request_n), .port_grant_select(bus.port_grant_select),
    .write_data_gate(bus.write_data_gate), .read_sample_strobe(bus.read_sample_strobe),
    .request_clear(bus.request_clear), .rd_wr_n(bus.rd_wr_n),
    .mem_data_oe(bus.mem_data_oe), .port_data_oe(bus.port_data_oe),
    .ram_row_strobe_n(row_n), .ram_col_strobe_n(col_n));

  // =====================
  // Tasks
  task automatic check(input logic [WIDE_W-1:0] seen, input logic [WIDE_W-1:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One user cycle on the CPU port, waited for under a bound
  task automatic mem_op(input logic rd, input logic wd, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    int n;
    @(negedge core_clk);
    usr_start = 1'b1;
    usr_read = rd;
    usr_wide = wd;
    usr_addr = a;
    usr_wdata = d;
    @(negedge core_clk);
    usr_start = 1'b0;
    check(64'(usr_busy), 64'h1);
    n = 0;
    while (usr_done !== 1'b1 && n < 40)
    begin
      @(negedge core_clk);
      n++;
    end
    check(64'(usr_done), 64'h1);
  endtask : mem_op

  task automatic end_sim();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  // =====================
  // Bus monitor and scripted requesters, all at the falling edge
  always @(negedge core_clk)
  begin
    cyc++;
    for (int i = 0; i < 3; i++)
      if (bus.port_grant_select[i] && !sel_q[i]) order_q.push_back(i);
    if (bus.port_grant_select[1] && !sel_q[1]) seen_addr = bus.addr;
    if (bus.port_grant_select[1] && !row_n && row_q) cpu_row = ram_addr;
    if (bus.port_grant_select[1] && !col_n && col_q) cpu_col = ram_addr;
    if (bus.port_grant_select[3] && !sel_q[3])
    begin
      if (cyc - last_ref > gap_max && last_ref > 0) gap_max = cyc - last_ref;
      last_ref = cyc;
    end
    // Refresh rows must step by one per grant
    if (bus.port_grant_select[3] && !row_n && row_q)
    begin
      if (ref_rows > 0) check(ram_addr, 7'(last_row + 7'h1));
      last_row = ram_addr;
      ref_rows++;
    end
    if (bus.request_clear && bus.port_grant_select[0]) disp_req_n = 1'b1;
    if (bus.request_clear && bus.port_grant_select[2]) fetch_req_n = 1'b1;
    sel_q = bus.port_grant_select;
    row_q = row_n;
    col_q = col_n;
  end

  // =====================
  // Main sequence
  initial
  begin
    base[0] = 18'h00000;
    base[1] = 18'h1fffc;
    repeat (12) @(negedge core_clk);
    rstn = 1'b1;
    // Narrow writes, narrow reads back, one wide read per block
    foreach (base[b])
    begin
      for (int i = 0; i < 4; i++)
      begin
        w[i] = 16'h5a00 + 16'h0111 * i + base[b][15:0];
        mem_op(1'b0, i == 3, base[b] + i, w[i]);
      end
      for (int i = 0; i < 4; i++)
      begin
        mem_op(1'b1, 1'b0, base[b] + i, '0);
        check(usr_rdata, w[i]);
      end
      mem_op(1'b1, 1'b1, base[b] + 2, '0);
      check(usr_wide_rdata, {w[3], w[2], w[1], w[0]});
      check(seen_addr, base[b] + 2);
      check(cpu_row, base[b][8:2]);
      check(cpu_col, base[b][15:9]);
    end
    // Display and fetch ask together, CPU a clock later: display, CPU, fetch in that order
    order_q.delete();
    @(negedge core_clk);
    disp_req_n = 1'b0;
    fetch_req_n = 1'b0;
    mem_op(1'b1, 1'b0, base[1] + 1, '0);
    repeat (15) @(negedge core_clk);
    check(order_q.size(), 3);
    foreach (order_q[k]) check(order_q[k], k);
    check(usr_rdata, w[1]);
    // Idle bus: refresh alone, gap bounded by the row interval
    gap_max = 0;
    ref_rows = 0;
    repeat (3 * REFRESH_CYC + 200) @(negedge core_clk);
    check(ref_rows >= 3, 1);
    check(gap_max <= REFRESH_CYC + 12, 1);
    end_sim();
  end

  // Hang guard, far beyond the expected few thousand cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end
endmodule : multiport_dram_memory_control_tb
